/* verilog/cps_pkg.sv */
// Shared constants and types for the charging port power block.
// Assumes one clock domain and a configuration loader on the same clock.
package cps_pkg;

	// ==========================================================
	// Configuration register map
	localparam logic [7:0] CPS_CHARGE_EN_ADDR  = 8'hD0;
	localparam logic [7:0] CPS_CHARGE_EN_RESET = 8'h00;
	localparam int         CPS_CHARGE_EN_LSB   = 1;
	localparam logic [7:0] CPS_READ_MISS       = 8'h00;
	localparam int         CPS_REG_WIDTH       = 8;

	// ==========================================================
	// Select pin encodings
	localparam logic [1:0] CPS_SEL_DEFAULT = 2'h0;
	localparam logic [1:0] CPS_SEL_SMBUS   = 2'h1;
	localparam logic [1:0] CPS_SEL_BUS_PWR = 2'h2;
	localparam logic [1:0] CPS_SEL_EEPROM  = 2'h3;

	// ==========================================================
	// Timing and sizing
	localparam int CPS_SYNC_STAGES = 2;
	localparam int CPS_MAX_PORTS   = 7;

	typedef enum logic [1:0] {
		CPS_SETTLE,
		CPS_SAMPLE,
		CPS_LOAD,
		CPS_READY
	} cps_state_e;

endpackage : cps_pkg

/* verilog/cps_port_if.sv */
// Control and status of one downstream port between the top and its power controller.
// Assumes every signal is on the single block clock.
`timescale 1ns/1ps

interface cps_port_if;
	logic cfg_done;
	logic charge_en;
	logic oc;
	logic host_on;
	logic host_off;
	logic enumerated;
	logic power;
	logic oc_status;

	modport ctl  (output cfg_done, charge_en, oc, host_on, host_off, enumerated,
	              input power, oc_status);
	modport port (input cfg_done, charge_en, oc, host_on, host_off, enumerated,
	              output power, oc_status);
endinterface : cps_port_if

/* verilog/cps_sync.sv */
// Multi-bit two-stage level synchroniser for pins.
// Assumes each bit is an independent level; no word coherence is given.
`timescale 1ns/1ps

module cps_sync #(
	parameter int   WIDTH       = 1,
	parameter int   STAGES      = 2,
	parameter logic RESET_LEVEL = 1'b0
) (
	input  wire logic             clock,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] stage_reg [STAGES];

	if (STAGES < 2 || WIDTH < 1) begin : g_bad
		$error("cps_sync needs at least two stages and one bit");
	end

	// Only the next stage ever reads stage 0.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			for (int k = 0; k < STAGES; k++) begin
				stage_reg[k] <= {WIDTH{RESET_LEVEL}};
			end
		end else begin
			stage_reg[0] <= din;
			for (int k = 1; k < STAGES; k++) begin
				stage_reg[k] <= stage_reg[k-1];
			end
		end
	end

	assign dout = stage_reg[STAGES-1];

endmodule // cps_sync

/* verilog/cps_port_power.sv */
// Power switch control for one downstream port.
// Assumes over-current is already synchronised and host commands are one-cycle pulses.
`timescale 1ns/1ps

module cps_port_power (
	input  wire logic clock,
	input  wire logic rst_b,
	cps_port_if.port  p
);
	logic fault_reg;
	logic fault_next;
	logic host_off_reg;
	logic host_off_next;
	logic host_hold_reg;
	logic host_hold_next;
	logic power_reg;
	logic power_next;
	logic oc_status_reg;

	// ==========================================================
	// Fault latch: an over-current in the clearing cycle still wins.
	assign fault_next     = p.oc | (fault_reg & ~p.host_on);
	assign host_off_next  = p.host_off | (host_off_reg & ~p.host_on);
	assign host_hold_next = (p.host_on & ~p.oc) | (host_hold_reg & ~p.host_off & ~p.oc);
	// Upstream bus sense and enumeration play no part in charging power.
	assign power_next     = p.cfg_done & ~p.oc &
	                        (host_hold_next | (p.charge_en & ~fault_next & ~host_off_next));

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			fault_reg     <= 1'b0;
			host_off_reg  <= 1'b0;
			host_hold_reg <= 1'b0;
			power_reg     <= 1'b0;
			oc_status_reg <= 1'b0;
		end else begin
			fault_reg     <= fault_next;
			host_off_reg  <= host_off_next;
			host_hold_reg <= host_hold_next;
			power_reg     <= power_next;
			oc_status_reg <= p.oc & p.enumerated;
		end
	end

	assign p.power     = power_reg;
	assign p.oc_status = oc_status_reg;

	a_fault_keeps_off: assert property (@(posedge clock) disable iff (!rst_b)
		(fault_reg && !p.host_on) |=> !power_reg)
		else $error("latched fault let port power come back on");

	a_oc_reported: assert property (@(posedge clock) disable iff (!rst_b)
		(p.oc && p.enumerated) |=> oc_status_reg)
		else $error("over-current not reported while enumerated");

endmodule // cps_port_power

/* verilog/cps_charge_port_power.sv */
// Top of the charging port power and configuration select block.
// Assumes a configuration loader on the same clock writes the charge enable
// register and pulses cfg_load_done; select, strap and fault pins are asynchronous.
`timescale 1ns/1ps

module cps_charge_port_power
	import cps_pkg::*;
#(
	parameter int NUM_PORTS = 4
) (
	input  wire logic                     clock,
	input  wire logic                     rst_b,
	input  wire logic [1:0]               cfg_sel_pin,
	input  wire logic [NUM_PORTS-1:0]     port_power_in,
	input  wire logic [NUM_PORTS-1:0]     over_current_n,
	input  wire logic                     upstream_vbus_sense,
	input  wire logic                     hub_enumerated,
	input  wire logic [NUM_PORTS-1:0]     host_power_on,
	input  wire logic [NUM_PORTS-1:0]     host_power_off,
	input  wire logic                     cfg_load_done,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	input  wire logic [7:0]               reg_addr,
	input  wire logic [CPS_REG_WIDTH-1:0] reg_wdata,
	output logic      [CPS_REG_WIDTH-1:0] reg_rdata,
	output logic                          reg_rvalid,
	output logic      [NUM_PORTS-1:0]     port_power_out,
	output logic      [NUM_PORTS-1:0]     port_power_oe,
	output logic      [NUM_PORTS-1:0]     port_oc_status,
	output logic      [1:0]               cfg_mode,
	output logic                          cfg_complete,
	output logic                          strap_active,
	output logic                          self_powered,
	output logic                          vbus_present
);

	if (NUM_PORTS < 1 || NUM_PORTS > CPS_MAX_PORTS) begin : g_bad_ports
		$error("NUM_PORTS must lie between 1 and the register width less one");
	end

	// ==========================================================
	// Pin synchronisers

	logic [1:0]           sel_sync;
	logic [NUM_PORTS-1:0] strap_sync;
	logic [NUM_PORTS-1:0] oc_n_sync;
	logic                 vbus_sync;

	cps_sync #(
		.WIDTH       (2),
		.STAGES      (CPS_SYNC_STAGES),
		.RESET_LEVEL (1'b0)
	) u_sel_sync (
		.clock (clock),
		.rst_b (rst_b),
		.din   (cfg_sel_pin),
		.dout  (sel_sync)
	);

	cps_sync #(
		.WIDTH       (NUM_PORTS),
		.STAGES      (CPS_SYNC_STAGES),
		.RESET_LEVEL (1'b0)
	) u_strap_sync (
		.clock (clock),
		.rst_b (rst_b),
		.din   (port_power_in),
		.dout  (strap_sync)
	);

	// Fault inputs reset to the inactive level so that reset alone never
	// looks like a short circuit.
	cps_sync #(
		.WIDTH       (NUM_PORTS),
		.STAGES      (CPS_SYNC_STAGES),
		.RESET_LEVEL (1'b1)
	) u_oc_sync (
		.clock (clock),
		.rst_b (rst_b),
		.din   (over_current_n),
		.dout  (oc_n_sync)
	);

	cps_sync #(
		.WIDTH       (1),
		.STAGES      (CPS_SYNC_STAGES),
		.RESET_LEVEL (1'b0)
	) u_vbus_sync (
		.clock (clock),
		.rst_b (rst_b),
		.din   (upstream_vbus_sense),
		.dout  (vbus_sync)
	);

	// ==========================================================
	// Configuration sequencer

	localparam logic [1:0] SETTLE_LAST = 2'(CPS_SYNC_STAGES - 1);

	cps_state_e           state_reg;
	cps_state_e           state_next;
	logic [1:0]           settle_reg;
	logic [1:0]           sel_reg;
	logic [NUM_PORTS-1:0] strap_reg;
	logic                 sel_internal;
	logic                 sel_bus_pwr;
	logic                 settled;
	logic                 ready;

	// The synchronisers hold reset values for the first edges after release,
	// so sampling waits until real pin levels have reached their outputs.
	assign settled      = (settle_reg == SETTLE_LAST);
	assign sel_internal = (sel_sync == CPS_SEL_DEFAULT) || (sel_sync == CPS_SEL_BUS_PWR);
	assign sel_bus_pwr  = (sel_sync == CPS_SEL_BUS_PWR);
	assign ready        = (state_reg == CPS_READY);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			CPS_SETTLE: begin
				if (settled) begin
					state_next = CPS_SAMPLE;
				end
			end
			CPS_SAMPLE: begin
				// Internal modes need no loader, so ports come up at once.
				state_next = sel_internal ? CPS_READY : CPS_LOAD;
			end
			CPS_LOAD: begin
				if (cfg_load_done) begin
					state_next = CPS_READY;
				end
			end
			CPS_READY: begin
				state_next = CPS_READY;
			end
			default: begin
				state_next = CPS_SETTLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state_reg  <= CPS_SETTLE;
			settle_reg <= 2'h0;
		end else begin
			state_reg  <= state_next;
			settle_reg <= settled ? settle_reg : settle_reg + 2'h1;
		end
	end

	// Select and strap levels are caught once, in the sample state only.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			sel_reg      <= CPS_SEL_DEFAULT;
			strap_reg    <= '0;
			strap_active <= 1'b0;
			self_powered <= 1'b1;
		end else if (state_reg == CPS_SAMPLE) begin
			sel_reg      <= sel_sync;
			strap_reg    <= sel_internal ? strap_sync : '0;
			strap_active <= sel_internal;
			self_powered <= !sel_bus_pwr;
		end
	end

	// ==========================================================
	// Charging enable register

	logic [CPS_REG_WIDTH-1:0] charge_en_reg;
	logic [CPS_REG_WIDTH-1:0] strap_word;
	logic [CPS_REG_WIDTH-1:0] rdata_next;
	logic [NUM_PORTS-1:0]     charge_en_vec;
	logic                     addr_hit;
	logic                     wr_accept;

	assign addr_hit  = (reg_addr == CPS_CHARGE_EN_ADDR);
	// Only the external loaders own the register; straps stand in otherwise.
	assign wr_accept = reg_wr && addr_hit && !strap_active &&
	                   (state_reg == CPS_LOAD || ready);
	assign strap_word = CPS_REG_WIDTH'(strap_reg) << CPS_CHARGE_EN_LSB;

	// In strapped modes the register reads back the enables actually in use.
	assign charge_en_vec = strap_active ? strap_reg
	                                    : charge_en_reg[CPS_CHARGE_EN_LSB +: NUM_PORTS];
	assign rdata_next    = !addr_hit    ? CPS_READ_MISS :
	                       strap_active ? strap_word    : charge_en_reg;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			charge_en_reg <= CPS_CHARGE_EN_RESET;
		end else if (wr_accept) begin
			charge_en_reg <= reg_wdata;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata  <= CPS_READ_MISS;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= rdata_next;
			end
		end
	end

	// ==========================================================
	// Status outputs

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			cfg_mode      <= CPS_SEL_DEFAULT;
			cfg_complete  <= 1'b0;
			vbus_present  <= 1'b0;
			port_power_oe <= '0;
		end else begin
			cfg_mode      <= sel_reg;
			cfg_complete  <= ready;
			vbus_present  <= vbus_sync;
			// The pins stay undriven until configuration ends so straps can be read.
			port_power_oe <= {NUM_PORTS{ready}};
		end
	end

	// ==========================================================
	// Per-port power controllers

	for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
		cps_port_if pif ();

		assign pif.cfg_done   = ready;
		assign pif.charge_en  = charge_en_vec[i];
		assign pif.oc         = !oc_n_sync[i];
		assign pif.host_on    = host_power_on[i] && hub_enumerated;
		assign pif.host_off   = host_power_off[i] && hub_enumerated;
		assign pif.enumerated = hub_enumerated;

		cps_port_power u_port (
			.clock (clock),
			.rst_b (rst_b),
			.p     (pif.port)
		);

		assign port_power_out[i] = pif.power;
		assign port_oc_status[i] = pif.oc_status;

		a_charge_power_on: assert property (@(posedge clock) disable iff (!rst_b)
			($rose(ready) && charge_en_vec[i] && oc_n_sync[i]) |=> port_power_out[i])
			else $error("charging port not powered after configuration");

		a_oc_power_off: assert property (@(posedge clock) disable iff (!rst_b)
			!oc_n_sync[i] |=> !port_power_out[i])
			else $error("port power stayed on during over-current");

		a_host_power_on: assert property (@(posedge clock) disable iff (!rst_b)
			(ready && hub_enumerated && host_power_on[i] && oc_n_sync[i])
			|=> port_power_out[i])
			else $error("host power-on command not obeyed");

		a_no_power_early: assert property (@(posedge clock) disable iff (!rst_b)
			!ready |=> !port_power_out[i])
			else $error("port powered before configuration finished");
	end

	// ==========================================================
	// Checks on configuration selection and the charge enable register

	a_sel_sampled: assert property (@(posedge clock) disable iff (!rst_b)
		(state_reg == CPS_SAMPLE) |-> ##2 (cfg_mode == $past(sel_sync, 2)))
		else $error("select value not taken from the sampled pins");

	a_sel_held: assert property (@(posedge clock) disable iff (!rst_b)
		(ready && $past(ready)) |=> $stable(sel_reg))
		else $error("select value changed after it was latched");

	a_ext_no_strap: assert property (@(posedge clock) disable iff (!rst_b)
		(cfg_complete && (cfg_mode == CPS_SEL_SMBUS || cfg_mode == CPS_SEL_EEPROM))
		|-> (!strap_active && charge_en_vec == charge_en_reg[CPS_CHARGE_EN_LSB +: NUM_PORTS]))
		else $error("straps in use under external configuration");

	a_bus_pwr_mode: assert property (@(posedge clock) disable iff (!rst_b)
		(cfg_complete && cfg_mode == CPS_SEL_BUS_PWR) |-> (!self_powered && strap_active))
		else $error("bus-powered select not applied");

	a_default_mode: assert property (@(posedge clock) disable iff (!rst_b)
		(cfg_complete && cfg_mode == CPS_SEL_DEFAULT) |-> (self_powered && strap_active))
		else $error("default select not applied");

	a_internal_fast: assert property (@(posedge clock) disable iff (!rst_b)
		(state_reg == CPS_SAMPLE && sel_internal) |=> ready ##1 cfg_complete)
		else $error("internal configuration did not finish at once");

	a_reg_write: assert property (@(posedge clock) disable iff (!rst_b)
		wr_accept |=> (charge_en_reg == $past(reg_wdata)))
		else $error("charge enable register did not take the write");

endmodule // cps_charge_port_power

/* tb/cps_partner.sv */
// Far-side model: downstream port power switches and the strap resistors on the shared pins.
// Assumes the bench sets strap levels and the shorts seen by each switch.
`timescale 1ns/1ps

module cps_partner #(
	parameter int N = 4
) (
	input  wire logic [N-1:0] port_power_out,
	input  wire logic [N-1:0] port_power_oe,
	input  wire logic [N-1:0] strap_level,
	input  wire logic [N-1:0] fault_req,
	output logic      [N-1:0] port_power_in,
	output logic      [N-1:0] over_current_n
);
	// ==========================================================
	// Pin levels
	// A released pin settles to its strap resistor, never to the last driven value.
	assign port_power_in  = (port_power_oe & port_power_out) | (~port_power_oe & strap_level);
	// The sense line follows the short itself, so a persisting short stays visible.
	assign over_current_n = ~fault_req;
endmodule // cps_partner

/* tb/cps_charge_port_power_tb.sv */
// Self-checking bench for the charging port power and configuration select block.
// Assumes the partner model in cps_partner and a 100 MHz clock.
`timescale 1ns/1ps

module cps_charge_port_power_tb;
	import cps_pkg::*;
	localparam int N = 4;
	logic       clock = 1'b0;
	logic       rst_b, upstream_vbus_sense, hub_enumerated, cfg_load_done, reg_wr, reg_rd;
	logic [1:0] cfg_sel_pin, cfg_mode;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, wv;
	logic       reg_rvalid, cfg_complete, strap_active, self_powered, vbus_present;
	logic [N-1:0] port_power_in, over_current_n, host_power_on, host_power_off;
	logic [N-1:0] port_power_out, port_power_oe, port_oc_status, strap_level, fault_req;
	logic [N-1:0] m_en, m_flt;
	int         fail_count = 0;
	int         n_tests = 0;
	int         seed = 32'h84EBEFCE;

	always #5 clock = ~clock;

	cps_charge_port_power #(.NUM_PORTS(N)) cps_charge_port_power_inst (
		.clock(clock), .rst_b(rst_b), .cfg_sel_pin(cfg_sel_pin),
		.port_power_in(port_power_in), .over_current_n(over_current_n),
		.upstream_vbus_sense(upstream_vbus_sense), .hub_enumerated(hub_enumerated),
		.host_power_on(host_power_on), .host_power_off(host_power_off),
		.cfg_load_done(cfg_load_done), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .port_power_out(port_power_out),
		.port_power_oe(port_power_oe), .port_oc_status(port_oc_status),
		.cfg_mode(cfg_mode), .cfg_complete(cfg_complete), .strap_active(strap_active),
		.self_powered(self_powered), .vbus_present(vbus_present));

	cps_partner #(.N(N)) cps_partner_inst (
		.port_power_out(port_power_out), .port_power_oe(port_power_oe),
		.strap_level(strap_level), .fault_req(fault_req),
		.port_power_in(port_power_in), .over_current_n(over_current_n));

	// ==========================================================
	// Shared tasks
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_pwr(input string what);
		chk(8'(port_power_out), 8'(m_en & ~m_flt), what);
	endtask

	task automatic pulse_on(input logic [N-1:0] v);
		host_power_on = v;
		cyc(1);
		host_power_on = '0;
		cyc(2);
	endtask

	task automatic do_reset(input logic [1:0] sel, input logic [N-1:0] strap);
		rst_b = 1'b0;
		cfg_sel_pin = sel;
		strap_level = strap;
		upstream_vbus_sense = 1'($random(seed));
		hub_enumerated = 1'b0;
		fault_req = '0;
		cyc(6);
		rst_b = 1'b1;
		cyc(6);
		m_flt = '0;
		m_en = (sel == CPS_SEL_DEFAULT || sel == CPS_SEL_BUS_PWR) ? strap : '0;
	endtask

	task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
		reg_wr = 1'b1;
		reg_addr = addr;
		reg_wdata = data;
		cyc(1);
		reg_wr = 1'b0;
		cyc(1);
	endtask

	task automatic reg_read(input logic [7:0] addr, input logic [7:0] exp);
		reg_rd = 1'b1;
		reg_addr = addr;
		cyc(1);
		reg_rd = 1'b0;
		chk(8'(reg_rvalid), 8'h01, "read valid");
		chk(reg_rdata, exp, "read data");
		cyc(1);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		{cfg_load_done, reg_wr, reg_rd} = '0;
		{reg_addr, reg_wdata, host_power_on, host_power_off} = '0;
		for (int s = 0; s < 4; s++) begin
			do_reset(2'(s), N'($random(seed)));
			chk(8'(cfg_mode), 8'(s), "mode");
			chk(8'(strap_active), 8'(s == 0 || s == 2), "strap use");
			chk(8'(self_powered), 8'(s != 2), "self powered");
			chk(8'(vbus_present), 8'(upstream_vbus_sense), "vbus");
			chk_pwr("power at config");
			chk(8'(cfg_complete), 8'(s == 0 || s == 2), "config at once");
			wv = 8'($random(seed));
			reg_write(CPS_CHARGE_EN_ADDR, wv);
			reg_write(8'hD1, ~wv);
			if (!strap_active) begin
				m_en = wv[N:1];
				cfg_load_done = 1'b1;
				cyc(1);
				cfg_load_done = 1'b0;
				for (int k = 0; k < 20 && cfg_complete !== 1'b1; k++)
					cyc(1);
				if (cfg_complete !== 1'b1) begin
					fail_count++;
					$display("[FAIL] %0t configuration never completed", $time);
					stop_test();
				end
			end
			cyc(2);
			chk_pwr("power after load");
			chk(8'(port_power_oe), 8'({N{1'b1}}), "drive enable");
			chk(8'(cfg_complete), 8'h01, "config complete");
			reg_read(CPS_CHARGE_EN_ADDR, strap_active ? 8'(strap_level) << 1 : wv);
			reg_read(8'hD1, CPS_READ_MISS);
			cfg_sel_pin = ~cfg_sel_pin;
			cyc(4);
			chk(8'(cfg_mode), 8'(s), "mode held");
			$display("select %0d test done", s);
		end
		do_reset(CPS_SEL_DEFAULT, '1);
		fault_req = 4'h1;
		cyc(4);
		m_flt = 4'h1;
		chk_pwr("fault off");
		fault_req = '0;
		cyc(4);
		chk_pwr("fault latched");
		pulse_on(4'h1);
		chk_pwr("host ignored unenumerated");
		hub_enumerated = 1'b1;
		fault_req = 4'h2;
		cyc(4);
		m_flt = 4'h3;
		chk(8'(port_oc_status), 8'h02, "fault report");
		pulse_on(4'h2);
		chk_pwr("host on refused");
		fault_req = '0;
		cyc(4);
		chk(8'(port_oc_status), 8'h00, "fault gone");
		pulse_on(4'h3);
		m_flt = '0;
		chk_pwr("host restores");
		host_power_off = 4'h4;
		cyc(1);
		host_power_off = '0;
		cyc(2);
		m_en = 4'hB;
		chk_pwr("host off");
		fault_req = 4'h8;
		cyc(4);
		m_flt = 4'h8;
		chk_pwr("fault off enumerated");
		chk(8'(port_oc_status), 8'h08, "fault report enumerated");
		do_reset(CPS_SEL_DEFAULT, '1);
		chk_pwr("reset clears fault");
		$display("fault test done");
		stop_test();
	end
endmodule // cps_charge_port_power_tb
